// File: logic/hal_pkg.sv
// Shared constants and types of the auto-mode link procedure engine.
package hal_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CFG = 8'h00;
	localparam logic [7:0] ADR_T1 = 8'h04;
	localparam logic [7:0] ADR_CMD = 8'h08;
	localparam logic [7:0] ADR_STAT = 8'h0c;

	// Configuration bits: modulus_select, normal_response_select,
	// timer_mode_bit, local receive-not-ready, retry count n1.
	localparam int CFG_MOD = 0;
	localparam int CFG_NRM = 1;
	localparam int CFG_TMD = 2;
	localparam int CFG_LRNR = 3;
	localparam int CFG_N1 = 4;
	localparam logic [7:0] CFG_RST = 8'h30;

	// Command bits, write-only, each one a one-cycle action.
	localparam int CMD_RECEIVER_RESET_CMD = 0;
	localparam int CMD_XIF = 1;
	localparam int CMD_XTR = 2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T1_RST_NS = 1000;
	localparam logic [15:0] T1_RST_CYC = 16'((T1_RST_NS * 1000) / CLK_PERIOD_PS);

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {FT_I = 2'b00, FT_S = 2'b01, FT_U = 2'b10} hal_ftype_e;
	typedef enum logic [1:0] {SF_RR = 2'b00, SF_RNR = 2'b01, SF_REJ = 2'b10} hal_sfn_e;
	typedef enum logic [1:0] {TK_S = 2'b00, TK_I = 2'b01, TK_T = 2'b10} hal_txk_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WACK = 3'b001,
		ST_POLL = 3'b010,
		ST_RNRP = 3'b011,
		ST_TINW = 3'b100
	} hal_st_e;
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_R = 3'b001,
		SEL_P = 3'b010,
		SEL_I = 3'b011,
		SEL_T = 3'b100
	} hal_sel_e;

	typedef struct packed {
		hal_ftype_e ftype;
		hal_sfn_e sfn;
		logic [6:0] ns;
		logic [6:0] nr;
		logic pf;
		logic is_cmd;
		logic crc_err;
		logic abort;
		logic has_info;
	} hal_rxfr_s;

	typedef struct packed {
		hal_txk_e kind;
		hal_sfn_e sfn;
		logic [6:0] ns;
		logic [6:0] nr;
		logic pf;
		logic is_cmd;
	} hal_txfr_s;

	typedef struct packed {
		logic all_sent_irq;
		logic message_repeat_irq;
		logic timeout_irq;
		logic rx_message_end_irq;
		logic rme_crc;
		logic rme_abort;
		logic protocol_error_irq;
		logic remote_status_irq;
		logic store;
	} hal_evt_s;
endpackage

// File: logic/hal_t1_timer.sv
// Retriggerable t1 supervision timer of the link procedure engine.
`timescale 1ns/1ps
module hal_t1_timer (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic [15:0] period_in,
	output logic expire_out
);
	logic [15:0] cnt_ff;
	logic run_ff;

	// ------------------------------------------------------------
	// Down counter
	// ------------------------------------------------------------
	// A start while running reloads, so every poll gets a full t1.
	// A period of zero behaves as one cycle, never as a stuck timer.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b0;
			expire_out <= 1'b0;
		end
		else
		begin
			expire_out <= 1'b0;
			if (stop_in)
				run_ff <= 1'b0;
			else if (start_in)
			begin
				run_ff <= 1'b1;
				cnt_ff <= period_in;
			end
			else if (run_ff)
			begin
				if (cnt_ff <= 16'h0001)
				begin
					expire_out <= 1'b1;
					run_ff <= 1'b0;
				end
				else
					cnt_ff <= cnt_ff - 16'h0001;
			end
		end
	end
endmodule

// File: logic/hal_link_engine.sv
// Auto-mode layer-2 procedure engine for one serial channel.
//
// Contract
// [R1] Modulo 8 or 128 sequence numbers selectable.
// [R2] Window one: compare counter LSBs only.
// [R3] Unnumbered frames go straight to host.
// [R4] Receiver reset reinitialises link state anytime.
// [R5] Reset default is combined balanced station.
// [R6] S-frames silent except status change, errors.
// [R7] I sequence error: discard, S-response, quiet.
// [R8] Local not-ready: reject I, send RNR.
// [R9] I-frame needs internal timer, then waits ack.
// [R10] No ack in t1: poll, retry n1 times.
// [R11] Ack or poll end: enable FIFO, interrupt.
// [R12] Host writes next frame after all-sent only.
// [R13] Remote RNR: poll every t1 until ready; the engine stops after n1 polls with a timeout.
// [R14] Retries exhausted: timeout, t1 later all-sent.
// [R15] Transparent frames allowed in every mode.
// [R16] I errors: CRC/abort end, N(S) S, N(R) error.
// [R17] S errors: CRC silent, N(R)/info protocol error.
// [R18] Erroneous frames leave V(S), V(R) unchanged.
// [R19] Config bit selects normal response secondary.
// [R20] Secondary sends only after poll received.
// [R21] Secondary queues I until poll, final set.
// [R22] Host sets addresses and modes before secondary.
`timescale 1ns/1ps
module hal_link_engine (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic rx_valid_in,
	input wire hal_pkg::hal_rxfr_s rx_frame_in,
	output logic tx_valid_out,
	output hal_pkg::hal_txfr_s tx_frame_out,
	input wire logic tx_ready_in,
	output logic tx_fifo_en_out,
	output hal_pkg::hal_evt_s evt_out
);
	logic [7:0] cfg_ff;
	logic [15:0] t1_ff;
	logic [6:0] vs_ff;
	logic [6:0] vr_ff;
	hal_pkg::hal_st_e st_ff;
	hal_pkg::hal_st_e nxt_st;
	logic [3:0] retry_ff;
	logic [3:0] nxt_retry;
	logic out_ff;
	logic rbusy_ff;
	logic pend_resp_ff;
	hal_pkg::hal_sfn_e resp_sfn_ff;
	logic resp_f_ff;
	logic pend_poll_ff;
	logic pend_info_ff;
	logic pend_trans_ff;
	logic permit_ff;
	hal_pkg::hal_evt_s evt_ff;
	logic m128;
	logic normal_response_select;
	logic timer_mode_bit;
	logic lrnr;
	logic [3:0] n1;
	logic cmd_receiver_reset_cmd;
	logic cmd_xif;
	logic cmd_xtr;
	logic go;
	logic good;
	logic nr_match;
	logic nr_bad;
	logic i_err;
	logic i_busy;
	logic i_seq;
	logic i_pce;
	logic i_good;
	logic s_pce;
	logic s_good;
	logic u_go;
	logic ack;
	logic fin;
	logic poll;
	logic s_rnr;
	logic s_rdy;
	logic expire;
	logic tmr_start;
	logic tmr_stop;
	logic e_all_sent_irq;
	logic e_xmr;
	logic e_tin;
	logic vs_back;
	logic poll_req;
	logic tx_acc;
	logic tx_i;
	hal_pkg::hal_sel_e sel;

	// Step a sequence variable up or down within the selected modulus.
	function automatic logic [6:0] seq_step(input logic [6:0] v, input logic wide,
		input logic up);
		logic [6:0] r;
		r = up ? v + 7'h01 : v - 7'h01;
		seq_step = wide ? r : {4'h0, r[2:0]};
	endfunction

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	// [R1] Modulus from configuration.
	assign m128 = cfg_ff[hal_pkg::CFG_MOD];
	assign normal_response_select = cfg_ff[hal_pkg::CFG_NRM];
	assign timer_mode_bit = cfg_ff[hal_pkg::CFG_TMD];
	assign lrnr = cfg_ff[hal_pkg::CFG_LRNR];
	assign n1 = cfg_ff[hal_pkg::CFG_N1 +: 4];
	assign cmd_receiver_reset_cmd = wr_in && addr_in == hal_pkg::ADR_CMD && wdata_in[hal_pkg::CMD_RECEIVER_RESET_CMD];
	assign cmd_xif = wr_in && addr_in == hal_pkg::ADR_CMD && wdata_in[hal_pkg::CMD_XIF];
	assign cmd_xtr = wr_in && addr_in == hal_pkg::ADR_CMD && wdata_in[hal_pkg::CMD_XTR];

	// [R5] Reset leaves the balanced combined station.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cfg_ff <= hal_pkg::CFG_RST;
			t1_ff <= hal_pkg::T1_RST_CYC;
		end
		else if (wr_in && addr_in == hal_pkg::ADR_CFG)
			cfg_ff <= wdata_in[7:0];
		else if (wr_in && addr_in == hal_pkg::ADR_T1)
			t1_ff <= wdata_in;
	end

	// Read data stand one cycle after each cycle of rd_in and are zero otherwise; unmapped offsets read zero.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			rdata_out <= 16'h0000;
		else if (!rd_in)
			rdata_out <= 16'h0000;
		else if (addr_in == hal_pkg::ADR_CFG)
			rdata_out <= {8'h00, cfg_ff};
		else if (addr_in == hal_pkg::ADR_T1)
			rdata_out <= t1_ff;
		else if (addr_in == hal_pkg::ADR_STAT)
			rdata_out <= {out_ff, rbusy_ff, vr_ff, vs_ff};
		else
			rdata_out <= 16'h0000;
	end

	// ------------------------------------------------------------
	// Received frame classification
	// ------------------------------------------------------------
	// [R2] Only bit 0 of N(S), N(R) is compared.
	// With one frame outstanding an N(R) LSB equal to V(S) acknowledges it;
	// with none outstanding a differing LSB can only be a stray N(R).
	always_comb
	begin
		go = rx_valid_in && !cmd_receiver_reset_cmd;
		good = !rx_frame_in.crc_err && !rx_frame_in.abort;
		nr_match = rx_frame_in.nr[0] == vs_ff[0];
		nr_bad = !out_ff && !nr_match;
		// [R16] I-frame error table.
		i_err = go && rx_frame_in.ftype == hal_pkg::FT_I && !good;
		// [R8] Local not-ready rejects I-frames.
		i_busy = go && rx_frame_in.ftype == hal_pkg::FT_I && good && lrnr;
		// [R7] Sequence error is answered, not reported.
		i_seq = go && rx_frame_in.ftype == hal_pkg::FT_I && good && !lrnr
			&& rx_frame_in.ns[0] != vr_ff[0];
		i_pce = go && rx_frame_in.ftype == hal_pkg::FT_I && good && !lrnr
			&& rx_frame_in.ns[0] == vr_ff[0] && nr_bad;
		i_good = go && rx_frame_in.ftype == hal_pkg::FT_I && good && !lrnr
			&& rx_frame_in.ns[0] == vr_ff[0] && !nr_bad;
		// [R17] S-frame errors; CRC and abort fall out silently.
		s_pce = go && rx_frame_in.ftype == hal_pkg::FT_S && good
			&& (rx_frame_in.has_info || nr_bad);
		s_good = go && rx_frame_in.ftype == hal_pkg::FT_S && good
			&& !rx_frame_in.has_info && !nr_bad;
		// [R3] Unnumbered frames are not interpreted.
		u_go = go && rx_frame_in.ftype == hal_pkg::FT_U;
		ack = (i_good || s_good) && out_ff && nr_match;
		fin = s_good && !rx_frame_in.is_cmd && rx_frame_in.pf;
		poll = (i_good || i_seq || i_busy || s_good) && rx_frame_in.is_cmd
			&& rx_frame_in.pf;
		s_rnr = s_good && rx_frame_in.sfn == hal_pkg::SF_RNR;
		s_rdy = s_good && rx_frame_in.sfn != hal_pkg::SF_RNR;
	end

	// ------------------------------------------------------------
	// Transmit selection
	// ------------------------------------------------------------
	// [R20] A secondary holds everything until it is polled.
	// [R15] Transparent frames pass in both modes.
	always_comb
	begin
		sel = hal_pkg::SEL_NONE;
		if (normal_response_select)
		begin
			if (permit_ff && pend_info_ff)
				sel = hal_pkg::SEL_I;
			else if (permit_ff && pend_trans_ff)
				sel = hal_pkg::SEL_T;
			else if (permit_ff && pend_resp_ff)
				sel = hal_pkg::SEL_R;
		end
		else if (pend_resp_ff)
			sel = hal_pkg::SEL_R;
		else if (pend_poll_ff)
			sel = hal_pkg::SEL_P;
		else if (pend_info_ff && st_ff == hal_pkg::ST_IDLE)
			sel = hal_pkg::SEL_I;
		else if (pend_trans_ff)
			sel = hal_pkg::SEL_T;
	end

	// [R21] A secondary's I-frame is a response with the final bit set.
	always_comb
	begin
		tx_frame_out.kind = hal_pkg::TK_S;
		tx_frame_out.sfn = lrnr ? hal_pkg::SF_RNR : hal_pkg::SF_RR;
		tx_frame_out.ns = vs_ff;
		tx_frame_out.nr = vr_ff;
		tx_frame_out.pf = 1'b1;
		tx_frame_out.is_cmd = 1'b1;
		unique case (sel)
			hal_pkg::SEL_R:
			begin
				tx_frame_out.sfn = resp_sfn_ff;
				tx_frame_out.pf = resp_f_ff;
				tx_frame_out.is_cmd = 1'b0;
			end
			hal_pkg::SEL_I:
			begin
				tx_frame_out.kind = hal_pkg::TK_I;
				tx_frame_out.pf = normal_response_select;
				tx_frame_out.is_cmd = !normal_response_select;
			end
			hal_pkg::SEL_T:
			begin
				tx_frame_out.kind = hal_pkg::TK_T;
				tx_frame_out.pf = 1'b0;
				tx_frame_out.is_cmd = 1'b0;
			end
			default:
			begin
				tx_frame_out.kind = hal_pkg::TK_S;
			end
		endcase
	end

	assign tx_valid_out = sel != hal_pkg::SEL_NONE;
	assign tx_acc = tx_valid_out && tx_ready_in;
	assign tx_i = tx_acc && sel == hal_pkg::SEL_I;
	// [R11] The transmit FIFO opens once the frame is settled.
	assign tx_fifo_en_out = !out_ff && !pend_info_ff;
	assign evt_out = evt_ff;

	// ------------------------------------------------------------
	// Acknowledgement supervision
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_retry = retry_ff;
		tmr_start = 1'b0;
		tmr_stop = 1'b0;
		e_all_sent_irq = 1'b0;
		e_xmr = 1'b0;
		e_tin = 1'b0;
		vs_back = 1'b0;
		poll_req = 1'b0;
		unique case (st_ff)
			hal_pkg::ST_IDLE:
			begin
				// [R9] Timer self-starts after an I-frame, in the balanced mode only.
				if (tx_i)
				begin
					nxt_st = hal_pkg::ST_WACK;
					nxt_retry = 4'h0;
					tmr_start = !normal_response_select;
				end
				// [R13] Remote busy starts periodic polling.
				else if (s_rnr && !normal_response_select)
				begin
					nxt_st = hal_pkg::ST_RNRP;
					nxt_retry = 4'h0;
					tmr_start = 1'b1;
				end
			end
			hal_pkg::ST_WACK, hal_pkg::ST_POLL:
			begin
				// [R11] Acknowledge, repeat or keep polling.
				if (ack)
				begin
					e_all_sent_irq = 1'b1;
					tmr_stop = 1'b1;
					nxt_st = hal_pkg::ST_IDLE;
				end
				else if (fin || (s_good && rx_frame_in.sfn == hal_pkg::SF_REJ))
				begin
					e_xmr = 1'b1;
					vs_back = 1'b1;
					tmr_stop = 1'b1;
					nxt_st = hal_pkg::ST_IDLE;
				end
				// [R10] Poll on expiry, at most n1 times.
				else if (expire && retry_ff < n1)
				begin
					poll_req = 1'b1;
					nxt_retry = retry_ff + 4'h1;
					tmr_start = 1'b1;
					nxt_st = hal_pkg::ST_POLL;
				end
				// [R14] Out of retries: timeout, then wait one t1.
				else if (expire)
				begin
					e_tin = 1'b1;
					tmr_start = 1'b1;
					nxt_st = hal_pkg::ST_TINW;
				end
			end
			hal_pkg::ST_RNRP:
			begin
				if (s_rdy || i_good)
				begin
					tmr_stop = 1'b1;
					nxt_st = hal_pkg::ST_IDLE;
				end
				// [R13] Query the remote after each t1, for the first n1 expiries only.
				else if (expire && retry_ff < n1)
				begin
					poll_req = 1'b1;
					nxt_retry = retry_ff + 4'h1;
					tmr_start = 1'b1;
				end
				else if (expire)
				begin
					e_tin = 1'b1;
					tmr_start = 1'b1;
					nxt_st = hal_pkg::ST_TINW;
				end
			end
			hal_pkg::ST_TINW:
			begin
				// [R14] All-sent one t1 after the timeout.
				if (expire)
				begin
					e_all_sent_irq = 1'b1;
					nxt_st = hal_pkg::ST_IDLE;
				end
			end
			default:
			begin
				nxt_st = hal_pkg::ST_IDLE;
			end
		endcase
	end

	hal_t1_timer u_t1 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(tmr_start),
		.stop_in(tmr_stop || cmd_receiver_reset_cmd),
		.period_in(t1_ff),
		.expire_out(expire)
	);

	// [R4] Receiver reset returns the link to its initial state.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || cmd_receiver_reset_cmd)
		begin
			st_ff <= hal_pkg::ST_IDLE;
			retry_ff <= 4'h0;
			out_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			retry_ff <= nxt_retry;
			if (tx_i)
				out_ff <= 1'b1;
			else if (e_all_sent_irq || e_xmr)
				out_ff <= 1'b0;
		end
	end

	// [R18] Only accepted frames move V(R); errored ones never do.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || cmd_receiver_reset_cmd)
		begin
			vs_ff <= 7'h00;
			vr_ff <= 7'h00;
		end
		else
		begin
			if (tx_i)
				vs_ff <= seq_step(vs_ff, m128, 1'b1);
			else if (vs_back)
				vs_ff <= seq_step(vs_ff, m128, 1'b0);
			if (i_good)
				vr_ff <= seq_step(vr_ff, m128, 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Pending transmit work
	// ------------------------------------------------------------
	// A new request other than an I-frame in the cycle its old one is taken survives.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || cmd_receiver_reset_cmd)
		begin
			pend_resp_ff <= 1'b0;
			resp_sfn_ff <= hal_pkg::SF_RR;
			resp_f_ff <= 1'b0;
			pend_poll_ff <= 1'b0;
			pend_trans_ff <= 1'b0;
			permit_ff <= 1'b0;
		end
		else
		begin
			if (tx_acc && sel == hal_pkg::SEL_R)
				pend_resp_ff <= 1'b0;
			// [R7] [R8] Answer with RR, or RNR while locally busy.
			if (i_good || i_seq || i_busy || (s_good && poll))
			begin
				pend_resp_ff <= 1'b1;
				resp_sfn_ff <= lrnr ? hal_pkg::SF_RNR : hal_pkg::SF_RR;
				resp_f_ff <= rx_frame_in.pf;
			end
			if (tx_acc && sel == hal_pkg::SEL_P)
				pend_poll_ff <= 1'b0;
			if (poll_req)
				pend_poll_ff <= 1'b1;
			if (tx_acc && sel == hal_pkg::SEL_T)
				pend_trans_ff <= 1'b0;
			if (cmd_xtr)
				pend_trans_ff <= 1'b1;
			// [R20] One frame per poll received.
			if (tx_acc && normal_response_select)
				permit_ff <= 1'b0;
			if (poll && normal_response_select)
				permit_ff <= 1'b1;
		end
	end

	// [R9] I-frames only with the internal timer, unless secondary.
	// [R19] The secondary needs no timer for its I-frames.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || cmd_receiver_reset_cmd)
			pend_info_ff <= 1'b0;
		else if (tx_i)
			pend_info_ff <= 1'b0;
		else if (cmd_xif && !out_ff && (normal_response_select || timer_mode_bit))
			pend_info_ff <= 1'b1;
	end

	// ------------------------------------------------------------
	// Host events
	// ------------------------------------------------------------
	// [R6] Of S-frames, only status changes and protocol errors reach the host.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || cmd_receiver_reset_cmd)
		begin
			rbusy_ff <= 1'b0;
			evt_ff <= '0;
		end
		else
		begin
			evt_ff <= '0;
			if (s_rnr)
				rbusy_ff <= 1'b1;
			else if (s_rdy)
				rbusy_ff <= 1'b0;
			evt_ff.remote_status_irq <= (s_rnr && !rbusy_ff) || (s_rdy && rbusy_ff);
			// [R16] [R17] Protocol errors and message end.
			evt_ff.protocol_error_irq <= i_pce || s_pce;
			evt_ff.rx_message_end_irq <= i_err;
			evt_ff.rme_crc <= i_err && rx_frame_in.crc_err;
			evt_ff.rme_abort <= i_err && rx_frame_in.abort;
			evt_ff.store <= i_good || u_go;
			evt_ff.all_sent_irq <= e_all_sent_irq;
			evt_ff.message_repeat_irq <= e_xmr;
			evt_ff.timeout_irq <= e_tin;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_seq_resp;
		i_seq |=> pend_resp_ff && !evt_ff.store && !evt_ff.rx_message_end_irq;
	endproperty
	a_seq_resp: assert property (p_seq_resp) else $error("seq error not answered"); // [R7]

	property p_busy_rnr;
		i_busy |=> pend_resp_ff && resp_sfn_ff == hal_pkg::SF_RNR && !evt_ff.store;
	endproperty
	a_busy_rnr: assert property (p_busy_rnr) else $error("busy without RNR"); // [R8]

	property p_u_store;
		u_go |=> evt_ff.store;
	endproperty
	a_u_store: assert property (p_u_store) else $error("U frame not passed"); // [R3]

	property p_receiver_reset_cmd;
		cmd_receiver_reset_cmd |=> vs_ff == 7'h00 && vr_ff == 7'h00 && st_ff == hal_pkg::ST_IDLE;
	endproperty
	a_receiver_reset_cmd: assert property (p_receiver_reset_cmd) else $error("receiver reset ignored"); // [R4]

	property p_i_wait;
		tx_i && !normal_response_select && !cmd_receiver_reset_cmd |=> st_ff == hal_pkg::ST_WACK && !tx_fifo_en_out;
	endproperty
	a_i_wait: assert property (p_i_wait) else $error("no ack wait after I"); // [R9]

	property p_tin;
		expire && st_ff == hal_pkg::ST_POLL && retry_ff >= n1 && !ack && !fin
			&& !s_good && !cmd_receiver_reset_cmd |=> evt_ff.timeout_irq && st_ff == hal_pkg::ST_TINW;
	endproperty
	a_tin: assert property (p_tin) else $error("timeout missing"); // [R14]

	property p_err_vr;
		(i_err || i_seq || i_pce || s_pce) && !cmd_receiver_reset_cmd |=> vr_ff == $past(vr_ff);
	endproperty
	a_err_vr: assert property (p_err_vr) else $error("V(R) moved on error"); // [R18]

	property p_crc_rme;
		i_err |=> evt_ff.rx_message_end_irq ##1 (!evt_ff.rx_message_end_irq || $past(i_err));
	endproperty
	a_crc_rme: assert property (p_crc_rme) else $error("message end missing"); // [R16]

	property p_s_pce;
		s_pce |=> evt_ff.protocol_error_irq && (!pend_resp_ff || $past(pend_resp_ff));
	endproperty
	a_s_pce: assert property (p_s_pce) else $error("S error not flagged"); // [R17]

	property p_nrm_quiet;
		normal_response_select && !permit_ff |-> !tx_valid_out;
	endproperty
	a_nrm_quiet: assert property (p_nrm_quiet) else $error("secondary sent unpolled"); // [R20]

	c_all_sent_irq: cover property (tx_i ##[1:1000] evt_ff.all_sent_irq);
	c_tin: cover property (evt_ff.timeout_irq ##[1:1000] evt_ff.all_sent_irq);
	c_xmr: cover property (evt_ff.message_repeat_irq);
	c_nrm_i: cover property (normal_response_select && tx_i);
endmodule

// File: dv/hal_rm.sv
// Remote station model that takes the frames the engine offers.
`timescale 1ns/1ps
module hal_rm (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic tx_valid_in,
	input wire hal_pkg::hal_txfr_s tx_frame_in,
	output logic tx_ready_out
);
	hal_pkg::hal_txfr_s q[$];
	initial tx_ready_out = 1'b0;
	// Take a frame at the edge; a slow line stalls for single random cycles.
	// Longer stalls could let t1 run out before the bench answers a poll.
	always @(posedge clk_in)
	begin
		if (tx_valid_in && tx_ready_out)
			q.push_back(tx_frame_in);
		tx_ready_out <= !slow_in || !tx_ready_out || (($urandom % 2) == 0);
	end
endmodule

// File: dv/tb.sv
// Self-checking bench of the link procedure engine.
`timescale 1ns/1ps
module tb;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wd = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rxv = 1'b0;
	logic slow = 1'b0;
	hal_pkg::hal_rxfr_s rxf = '0;
	logic [15:0] rdata;
	logic txv;
	logic txr;
	logic fen;
	hal_pkg::hal_txfr_s txf;
	hal_pkg::hal_evt_s ev;
	int errors = 0;
	int total_checks = 0;
	int vs = 0;
	int vr = 0;
	int ec[9];
	logic [15:0] d;

	hal_link_engine hal_link_engine_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_valid_in(rxv),
		.rx_frame_in(rxf), .tx_valid_out(txv), .tx_frame_out(txf), .tx_ready_in(txr),
		.tx_fifo_en_out(fen), .evt_out(ev));
	hal_rm hal_rm_i (.clk_in(clk_in), .slow_in(slow), .tx_valid_in(txv),
		.tx_frame_in(txf), .tx_ready_out(txr));

	// Free-running 200 MHz clock.
	always #2.5 clk_in = ~clk_in;

	// Count every event pulse so lost or doubled pulses both show.
	always @(posedge clk_in)
		for (int i = 0; i < 9; i++)
			ec[i] += int'(ev[i]);

	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task chk(input logic [23:0] g, input logic [23:0] e);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Poll and response numbers in N(S) and the I-frame function code are don't-care.
	task chk_tx(input hal_pkg::hal_txfr_s g, input hal_pkg::hal_txfr_s e);
		if (e.kind == hal_pkg::TK_S)
			e.ns = g.ns;
		else
			e.sfn = g.sfn;
		chk(24'(g), 24'(e));
	endtask

	// Exactly the masked events must have pulsed once, and no frame taken by the remote may be left unchecked.
	task chk_ev(input logic [8:0] m);
		#1;
		for (int i = 0; i < 9; i++)
			chk(24'(ec[i]), 24'(m[i]));
		chk(24'(hal_rm_i.q.size()), 24'h0);
		foreach (ec[i])
			ec[i] = 0;
	endtask

	task wr_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_in);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	task rd_reg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task rx(input logic [1:0] ft, sf, input int ns, nr, input logic pf, c, input logic [1:0] er,
		input logic inf);
		@(posedge clk_in);
		rxv <= 1'b1;
		rxf <= '{hal_pkg::hal_ftype_e'(ft), hal_pkg::hal_sfn_e'(sf), 7'(ns), 7'(nr), pf, c,
			er[1], er[0], inf};
		@(posedge clk_in);
		rxv <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask

	function hal_pkg::hal_txfr_s fr(logic [1:0] k, s, int ns, nr, logic pf, c);
		return '{hal_pkg::hal_txk_e'(k), hal_pkg::hal_sfn_e'(s), 7'(ns), 7'(nr), pf, c};
	endfunction

	// Bounded wait for the next frame taken by the remote model.
	task get_tx(input hal_pkg::hal_txfr_s e);
		int n;
		n = 0;
		while (hal_rm_i.q.size() == 0 && n < 300)
		begin
			@(posedge clk_in);
			n++;
		end
		if (hal_rm_i.q.size() == 0)
			chk(24'hffffff, 24'(e));
		else
			chk_tx(hal_rm_i.q.pop_front(), e);
	endtask

	task end_sim;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog: the whole sequence needs a few hundred cycles.
	initial
	begin
		#200us;
		errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h08c6));
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd_reg(hal_pkg::ADR_CFG, d);
		chk(24'(d), 24'h30);
		rd_reg(hal_pkg::ADR_T1, d);
		chk(24'(d), 24'(hal_pkg::T1_RST_CYC));
		rd_reg(8'h10, d);
		chk(24'(d), 24'h0);
		chk(24'(fen), 24'h1);
		wr_reg(hal_pkg::ADR_CMD, 16'h0002);
		repeat (8) @(posedge clk_in);
		chk_ev(9'h000);
		wr_reg(hal_pkg::ADR_T1, 16'h0004);
		wr_reg(hal_pkg::ADR_CFG, 16'h0034);
		wr_reg(hal_pkg::ADR_CMD, 16'h0002);
		get_tx(fr(hal_pkg::TK_I, 0, vs, vr, 0, 1));
		vs = (vs + 1) % 8;
		#1 chk(24'(fen), 24'h0);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs, 0, 0, 2'b00, 0);
		chk_ev(9'h100);
		chk(24'(fen), 24'h1);
		// Good frame with random upper sequence bits, then the same one again.
		rx(hal_pkg::FT_I, 0, ($urandom % 64) * 2 + vr % 2, vs, 1, 1, 2'b00, 0);
		vr = (vr + 1) % 8;
		get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RR, 0, vr, 1, 0));
		chk_ev(9'h001);
		rx(hal_pkg::FT_I, 0, ($urandom % 64) * 2 + 1 - vr % 2, vs, 0, 1, 2'b00, 0);
		get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RR, 0, vr, 0, 0));
		chk_ev(9'h000);
		wr_reg(hal_pkg::ADR_CFG, 16'h003c);
		rx(hal_pkg::FT_I, 0, vr, vs, 0, 1, 2'b00, 0);
		get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RNR, 0, vr, 0, 0));
		chk_ev(9'h000);
		wr_reg(hal_pkg::ADR_CFG, 16'h0034);
		slow <= 1'b1;
		rx(hal_pkg::FT_I, 0, vr, vs, 0, 1, 2'b10, 0);
		chk_ev(9'h030);
		rx(hal_pkg::FT_I, 0, vr, vs, 0, 1, 2'b01, 0);
		chk_ev(9'h028);
		rx(hal_pkg::FT_I, 0, vr, vs + 1, 0, 1, 2'b00, 0);
		chk_ev(9'h004);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs, 0, 1, 2'b10, 0);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs, 0, 1, 2'b01, 0);
		chk_ev(9'h000);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs + 1, 0, 1, 2'b00, 0);
		chk_ev(9'h004);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs, 0, 1, 2'b00, 1);
		chk_ev(9'h004);
		rx(hal_pkg::FT_U, 0, 0, 0, 1, 1, 2'b00, 0);
		chk_ev(9'h001);
		rd_reg(hal_pkg::ADR_STAT, d);
		chk(24'(d), 24'((vr << 7) | vs));
		// Remote not ready: polled each t1 until it reports ready; both changes pulse.
		rx(hal_pkg::FT_S, hal_pkg::SF_RNR, 0, vs, 0, 1, 2'b00, 0);
		get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RR, 0, vr, 1, 1));
		chk_ev(9'h002);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, vs, 1, 0, 2'b00, 0);
		chk_ev(9'h002);
		// No acknowledgement ever comes: n1 polls, then timeout and all-sent.
		wr_reg(hal_pkg::ADR_CMD, 16'h0002);
		get_tx(fr(hal_pkg::TK_I, 0, vs, vr, 0, 1));
		vs = (vs + 1) % 8;
		repeat (3) get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RR, 0, vr, 1, 1));
		repeat (60) @(posedge clk_in);
		chk_ev(9'h140);
		wr_reg(hal_pkg::ADR_CMD, 16'h0001);
		vs = 0;
		vr = 0;
		rd_reg(hal_pkg::ADR_STAT, d);
		chk(24'(d), 24'h0);
		// A transparent frame goes straight out in the balanced mode.
		wr_reg(hal_pkg::ADR_CMD, 16'h0004);
		get_tx(fr(hal_pkg::TK_T, 0, 0, 0, 0, 0));
		// A final answer that does not acknowledge asks for a repeat.
		wr_reg(hal_pkg::ADR_CMD, 16'h0002);
		get_tx(fr(hal_pkg::TK_I, 0, 0, 0, 0, 1));
		get_tx(fr(hal_pkg::TK_S, hal_pkg::SF_RR, 0, 0, 1, 1));
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, 0, 1, 0, 2'b00, 0);
		chk_ev(9'h080);
		// Secondary: sends nothing until polled, then the frame with final set.
		wr_reg(hal_pkg::ADR_CFG, 16'h0032);
		wr_reg(hal_pkg::ADR_CMD, 16'h0002);
		repeat (20) @(posedge clk_in);
		chk_ev(9'h000);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, 0, 1, 1, 2'b00, 0);
		get_tx(fr(hal_pkg::TK_I, 0, 0, 0, 1, 0));
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, 1, 0, 1, 2'b00, 0);
		chk_ev(9'h100);
		// A secondary's transparent frame also waits for a poll.
		wr_reg(hal_pkg::ADR_CMD, 16'h0004);
		repeat (10) @(posedge clk_in);
		chk_ev(9'h000);
		rx(hal_pkg::FT_S, hal_pkg::SF_RR, 0, 1, 1, 1, 2'b00, 0);
		get_tx(fr(hal_pkg::TK_T, 0, 1, 0, 0, 0));
		end_sim();
	end
endmodule
